//--- core/udsc_pkg.sv
package udsc_pkg;

   // bus widths and endpoint count
   localparam int unsigned ADDR_W  = 8;
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned NUM_EP  = 6;
   localparam int unsigned FRAME_W = 11;
   localparam int unsigned FADDR_W = 7;
   localparam int unsigned KIND_W  = 3;
   localparam int unsigned BYTE_W  = 8;

   // register byte offsets
   localparam logic [7:0] OFS_FRAME    = 8'h00;
   localparam logic [7:0] OFS_GLOBAL   = 8'h04;
   localparam logic [7:0] OFS_FADDR    = 8'h08;
   localparam logic [7:0] OFS_IRQ_EN   = 8'h10;
   localparam logic [7:0] OFS_IRQ_DIS  = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
   localparam logic [7:0] OFS_IRQ_CLR  = 8'h20;
   localparam logic [7:0] OFS_EP_RST   = 8'h28;
   localparam logic [7:0] OFS_EP_CSR   = 8'h30;
   localparam logic [7:0] OFS_EP_FIFO  = 8'h50;
   localparam logic [7:0] OFS_XCVR     = 8'h74;
   localparam logic [7:0] EP_STRIDE    = 8'h04;

   // field positions
   localparam int unsigned BIT_ADDR_EN  = 0;
   localparam int unsigned BIT_CONFIG   = 1;
   localparam int unsigned BIT_FUNC_ON  = 8;
   localparam int unsigned BIT_XCVR_OFF = 8;
   localparam int unsigned BIT_PULLUP   = 9;
   localparam int unsigned BIT_FRM_ERR  = 16;
   localparam int unsigned BIT_FRM_OK   = 17;
   localparam int unsigned CSR_EP_EN    = 15;
   localparam int unsigned CSR_KIND_LO  = 8;
   localparam int unsigned IRQ_SUSPEND  = 8;
   localparam int unsigned IRQ_RESUME   = 9;
   localparam int unsigned IRQ_EXT_RSM  = 10;
   localparam int unsigned IRQ_SOF      = 11;
   localparam int unsigned IRQ_END_RST  = 12;
   localparam int unsigned IRQ_WAKEUP   = 13;

   // reset values and bit groups
   localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
   localparam logic [31:0] RST_FADDR   = 32'h0000_0100;
   localparam logic [31:0] RST_MASK    = 32'h0000_1200;
   localparam logic [31:0] RST_XCVR    = 32'h0000_0100;
   localparam logic [31:0] IRQ_VALID   = 32'h0000_3F3F;
   localparam logic [31:0] IRQ_STICKY  = 32'h0000_3F00;

   // device states
   typedef enum logic [2:0] {
      ST_ATTACHED   = 3'h0,
      ST_POWERED    = 3'h1,
      ST_DEFAULT    = 3'h2,
      ST_ADDRESS    = 3'h3,
      ST_CONFIGURED = 3'h4
   } udsc_state_t;

   // bus conditions reported by the serial engine
   typedef struct packed {
      logic               end_of_reset;
      logic               suspend;
      logic               ext_resume;
      logic               sof;
      logic               frame_err;
      logic [FRAME_W-1:0] frame_num;
   } udsc_bus_evt_t;

endpackage : udsc_pkg

//--- core/udsc_top.sv
// Function
// - state moves only on bus events or software
// - end of bus reset sets unmaskable flag, interrupts
// - end of reset restores mask and clears endpoint control registers
// - suspend sets flag, interrupt only when masked in
// - suspend flag cleared by clear write, not read
// - resume detected asynchronously with clocks stopped
// - resume sets wakeup flag, interrupt when masked in
// - pullup bit connects the dp pullup
// - transceiver off bit disables the transceiver
// - dp pullup stays connected during suspend
// - endpoint control registers at 0x030 plus four
// - endpoint fifo registers at 0x050 plus four
// - enable write of one sets mask bit
// - disable write of one clears mask bit
`timescale 1ns/100ps
`default_nettype none
module udsc_top (
   input  wire logic                                     ref_clk_i,
   input  wire logic                                     reset_i,
   input  wire logic [udsc_pkg::ADDR_W-1:0]              reg_addr_i,
   input  wire logic [udsc_pkg::DATA_W-1:0]              reg_wdata_i,
   input  wire logic                                     reg_wr_i,
   input  wire logic                                     reg_rd_i,
   output logic      [udsc_pkg::DATA_W-1:0]              reg_rdata_o,
   input  wire udsc_pkg::udsc_bus_evt_t                  bus_evt_i,
   input  wire logic                                     bus_resume_i,
   input  wire logic [udsc_pkg::NUM_EP-1:0]              ep_event_i,
   input  wire logic [udsc_pkg::BYTE_W-1:0]              ep_fifo_rdata_i,
   output logic      [udsc_pkg::NUM_EP-1:0]              ep_fifo_rd_o,
   output logic      [udsc_pkg::NUM_EP-1:0]              ep_fifo_wr_o,
   output logic      [udsc_pkg::BYTE_W-1:0]              ep_fifo_wdata_o,
   output logic      [udsc_pkg::NUM_EP-1:0]              ep_enable_o,
   output logic      [udsc_pkg::NUM_EP-1:0]              ep_reset_o,
   output logic      [udsc_pkg::NUM_EP*udsc_pkg::KIND_W-1:0] ep_kind_o,
   output logic                                          irq_o,
   output logic                                          pullup_dp_o,
   output logic                                          xcvr_off_o,
   output logic                                          func_on_o,
   output logic      [udsc_pkg::FADDR_W-1:0]             func_addr_o,
   output udsc_pkg::udsc_state_t                         dev_state_o,
   output logic                                          suspended_o
);
   import udsc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   logic [DATA_W-1:0]  mask_r;                 // interrupt mask
   logic [DATA_W-1:0]  mask_nxt;
   logic [DATA_W-1:0]  status_r;               // sticky interrupt flags
   logic [DATA_W-1:0]  status_nxt;
   logic [DATA_W-1:0]  stat_set;               // flags raised this cycle
   logic [DATA_W-1:0]  stat_view;              // sticky plus live endpoint bits
   logic [DATA_W-1:0]  csr_r [NUM_EP];         // endpoint control and status
   logic [NUM_EP-1:0]  ep_rst_r;               // endpoint reset register
   logic [FRAME_W-1:0] frame_num_r;            // last frame number
   logic               frame_ok_r;             // last frame clean
   logic               frame_err_r;            // last frame corrupt
   logic               addr_en_r;              // address state enable
   logic               config_r;               // configured
   logic [FADDR_W-1:0] faddr_r;                // function address
   logic               func_on_r;              // function enable
   logic               xcvr_off_r;             // transceiver off
   logic               pullup_r;               // dp pullup connect
   logic               suspended_r;            // bus suspended
   udsc_state_t        state_r;                // device state
   udsc_state_t        state_nxt;
   logic [DATA_W-1:0]  rdata_r;                // registered read data
   logic [DATA_W-1:0]  rd_mux;                 // selected read value
   logic [DATA_W-1:0]  frame_view;             // frame number word
   logic [DATA_W-1:0]  glb_view;               // global state word
   logic [DATA_W-1:0]  faddr_view;             // function address word
   logic [DATA_W-1:0]  xcvr_view;              // transceiver word
   logic [DATA_W-1:0]  csr_view;               // selected endpoint word
   logic [NUM_EP-1:0]  fifo_wr_r;              // fifo write strobes
   logic [BYTE_W-1:0]  fifo_wdata_r;           // fifo write byte
   logic               rsm_latch_r;            // async resume catch
   logic               rsm_meta_r;             // first sync stage
   logic               rsm_sync_r;             // second sync stage
   logic               rsm_prev_r;             // edge reference
   logic               resume_evt;             // one cycle resume pulse
   logic               end_rst;                // end of bus reset pulse

   // address decode
   wire                sel_frame  = (reg_addr_i == OFS_FRAME);
   wire                sel_glb    = (reg_addr_i == OFS_GLOBAL);
   wire                sel_faddr  = (reg_addr_i == OFS_FADDR);
   wire                sel_en     = (reg_addr_i == OFS_IRQ_EN);
   wire                sel_dis    = (reg_addr_i == OFS_IRQ_DIS);
   wire                sel_mask   = (reg_addr_i == OFS_IRQ_MASK);
   wire                sel_stat   = (reg_addr_i == OFS_IRQ_STAT);
   wire                sel_clr    = (reg_addr_i == OFS_IRQ_CLR);
   wire                sel_eprst  = (reg_addr_i == OFS_EP_RST);
   wire                sel_xcvr   = (reg_addr_i == OFS_XCVR);
   wire [NUM_EP-1:0]   sel_csr;                // one hot endpoint control
   wire [NUM_EP-1:0]   sel_fifo;               // one hot endpoint fifo

   // write qualifiers
   wire [DATA_W-1:0]   wr_en_bits  = (reg_wr_i && sel_en)  ? reg_wdata_i : RST_ZERO;
   wire [DATA_W-1:0]   wr_dis_bits = (reg_wr_i && sel_dis) ? reg_wdata_i : RST_ZERO;
   wire [DATA_W-1:0]   wr_clr_bits = (reg_wr_i && sel_clr) ? reg_wdata_i : RST_ZERO;

   ////////////////////////////////////////////////////////////////////////////
   // decode helpers

   // match an endpoint slot above a base
   function automatic logic ep_hit(input logic [7:0] a, input logic [7:0] base,
                                   input int unsigned e);
      ep_hit = (a == 8'(base + EP_STRIDE * e));
   endfunction : ep_hit

   // per endpoint decode and outputs
   for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
      assign sel_csr[e]  = ep_hit(reg_addr_i, OFS_EP_CSR, e);
      assign sel_fifo[e] = ep_hit(reg_addr_i, OFS_EP_FIFO, e);
      assign ep_enable_o[e] = csr_r[e][CSR_EP_EN];
      assign ep_kind_o[e*KIND_W +: KIND_W] = csr_r[e][CSR_KIND_LO +: KIND_W];
   end

   ////////////////////////////////////////////////////////////////////////////
   // asynchronous resume capture

   // set by the bus itself, so it works with the clock stopped
   always_ff @(posedge ref_clk_i or posedge bus_resume_i) begin
      if (bus_resume_i) begin
         rsm_latch_r <= 1'b1;
      end else if (reset_i || rsm_sync_r) begin
         rsm_latch_r <= 1'b0;                  // released once seen in-domain
      end
   end

   // two stage synchroniser plus edge reference
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         rsm_meta_r <= 1'b0;
         rsm_sync_r <= 1'b0;
         rsm_prev_r <= 1'b0;
      end else begin
         rsm_meta_r <= rsm_latch_r;
         rsm_sync_r <= rsm_meta_r;
         rsm_prev_r <= rsm_sync_r;
      end
   end

   assign resume_evt = rsm_sync_r && !rsm_prev_r;
   assign end_rst    = bus_evt_i.end_of_reset;

   ////////////////////////////////////////////////////////////////////////////
   // interrupt flags and mask

   // events raising sticky flags
   always_comb begin
      stat_set              = RST_ZERO;
      stat_set[IRQ_SUSPEND] = bus_evt_i.suspend;
      stat_set[IRQ_RESUME]  = resume_evt;
      stat_set[IRQ_EXT_RSM] = bus_evt_i.ext_resume;
      stat_set[IRQ_SOF]     = bus_evt_i.sof;
      stat_set[IRQ_END_RST] = end_rst;
      stat_set[IRQ_WAKEUP]  = resume_evt;
   end

   // set wins over a clear in the same cycle; reads never clear
   assign status_nxt = ((status_r & ~(wr_clr_bits & IRQ_STICKY)) | stat_set)
                       & IRQ_STICKY;

   // enable sets, disable clears, end of reset restores
   assign mask_nxt = end_rst ? RST_MASK
                   : ((mask_r | wr_en_bits) & ~wr_dis_bits) & IRQ_VALID;

   // endpoint bits are live levels from the endpoints
   assign stat_view = status_r | {{(DATA_W-NUM_EP){1'b0}}, ep_event_i};

   // end of reset ignores the mask
   assign irq_o = (|(stat_view & mask_r)) || stat_view[IRQ_END_RST];

   // flag and mask storage
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         status_r <= RST_ZERO;
         mask_r   <= RST_MASK;
      end else begin
         status_r <= status_nxt;
         mask_r   <= mask_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // endpoint registers

   // control words, cleared by every end of reset
   always_ff @(posedge ref_clk_i) begin
      for (int e = 0; e < NUM_EP; e++) begin
         if (reset_i || end_rst) begin
            csr_r[e] <= RST_ZERO;
         end else if (reg_wr_i && sel_csr[e]) begin
            csr_r[e] <= reg_wdata_i;
         end
      end
   end

   // endpoint reset bits and fifo write strobes
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         ep_rst_r     <= '0;
         fifo_wr_r    <= '0;
         fifo_wdata_r <= '0;
      end else begin
         if (reg_wr_i && sel_eprst) begin
            ep_rst_r <= reg_wdata_i[NUM_EP-1:0];
         end
         fifo_wr_r <= sel_fifo & {NUM_EP{reg_wr_i}};
         if (reg_wr_i && (|sel_fifo)) begin
            fifo_wdata_r <= reg_wdata_i[BYTE_W-1:0];
         end
      end
   end

   assign ep_reset_o      = ep_rst_r;
   assign ep_fifo_wr_o    = fifo_wr_r;
   assign ep_fifo_wdata_o = fifo_wdata_r;
   assign ep_fifo_rd_o    = sel_fifo & {NUM_EP{reg_rd_i}};   // head byte taken now

   ////////////////////////////////////////////////////////////////////////////
   // global state, address, transceiver, frame

   // software state bits; end of reset returns to default
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || end_rst) begin
         addr_en_r <= 1'b0;
         config_r  <= 1'b0;
         faddr_r   <= RST_FADDR[FADDR_W-1:0];
         func_on_r <= RST_FADDR[BIT_FUNC_ON];
      end else begin
         if (reg_wr_i && sel_glb) begin
            // writing zero to address enable has no effect
            addr_en_r <= addr_en_r || reg_wdata_i[BIT_ADDR_EN];
            config_r  <= reg_wdata_i[BIT_CONFIG] && (addr_en_r || reg_wdata_i[BIT_ADDR_EN]);
         end
         if (reg_wr_i && sel_faddr) begin
            faddr_r   <= reg_wdata_i[FADDR_W-1:0];
            func_on_r <= reg_wdata_i[BIT_FUNC_ON];
         end
      end
   end

   // transceiver control; bus reset leaves it alone
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         xcvr_off_r <= RST_XCVR[BIT_XCVR_OFF];
         pullup_r   <= RST_XCVR[BIT_PULLUP];
      end else if (reg_wr_i && sel_xcvr) begin
         xcvr_off_r <= reg_wdata_i[BIT_XCVR_OFF];
         pullup_r   <= reg_wdata_i[BIT_PULLUP];
      end
   end

   // pullup follows only its bit, suspend never drops it
   assign pullup_dp_o = pullup_r;
   assign xcvr_off_o  = xcvr_off_r;
   assign func_on_o   = func_on_r;
   assign func_addr_o = faddr_r;

   // frame number captured at each start of frame
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         frame_num_r <= '0;
         frame_ok_r  <= 1'b0;
         frame_err_r <= 1'b0;
      end else if (bus_evt_i.sof) begin
         frame_num_r <= bus_evt_i.frame_num;
         frame_ok_r  <= !bus_evt_i.frame_err;
         frame_err_r <= bus_evt_i.frame_err;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // device state machine

   // moves only on bus conditions or software state bits
   always_comb begin
      state_nxt = state_r;
      if (!pullup_r) begin
         state_nxt = ST_ATTACHED;
      end else if (end_rst) begin
         state_nxt = ST_DEFAULT;
      end else begin
         case (state_r)
            ST_ATTACHED:   state_nxt = ST_POWERED;
            ST_POWERED:    state_nxt = ST_POWERED;
            ST_DEFAULT:    if (addr_en_r) state_nxt = ST_ADDRESS;
            ST_ADDRESS:    if (config_r) state_nxt = ST_CONFIGURED;
            ST_CONFIGURED: if (!config_r) state_nxt = ST_ADDRESS;
            default:       state_nxt = ST_ATTACHED;
         endcase
      end
   end

   // state and suspend storage
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state_r     <= ST_ATTACHED;
         suspended_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (end_rst || resume_evt) begin
            suspended_r <= 1'b0;
         end else if (bus_evt_i.suspend) begin
            suspended_r <= 1'b1;
         end
      end
   end

   assign dev_state_o = state_r;
   assign suspended_o = suspended_r;

   ////////////////////////////////////////////////////////////////////////////
   // read path

   // assemble register words
   always_comb begin
      frame_view                 = RST_ZERO;
      frame_view[FRAME_W-1:0]    = frame_num_r;
      frame_view[BIT_FRM_ERR]    = frame_err_r;
      frame_view[BIT_FRM_OK]     = frame_ok_r;
      glb_view                   = RST_ZERO;
      glb_view[BIT_ADDR_EN]      = addr_en_r;
      glb_view[BIT_CONFIG]       = config_r;
      faddr_view                 = RST_ZERO;
      faddr_view[FADDR_W-1:0]    = faddr_r;
      faddr_view[BIT_FUNC_ON]    = func_on_r;
      xcvr_view                  = RST_ZERO;
      xcvr_view[BIT_XCVR_OFF]    = xcvr_off_r;
      xcvr_view[BIT_PULLUP]      = pullup_r;
      csr_view                   = RST_ZERO;
      for (int e = 0; e < NUM_EP; e++) begin
         if (sel_csr[e]) begin
            csr_view = csr_r[e];
         end
      end
   end

   // write only and unmapped words read zero
   assign rd_mux = sel_frame  ? frame_view
                 : sel_glb    ? glb_view
                 : sel_faddr  ? faddr_view
                 : sel_mask   ? mask_r
                 : sel_stat   ? stat_view
                 : sel_eprst  ? {{(DATA_W-NUM_EP){1'b0}}, ep_rst_r}
                 : sel_xcvr   ? xcvr_view
                 : (|sel_csr) ? csr_view
                 : (|sel_fifo) ? {{(DATA_W-BYTE_W){1'b0}}, ep_fifo_rdata_i}
                 : RST_ZERO;

   // data valid only in the cycle after the strobe
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         rdata_r <= RST_ZERO;
      end else begin
         rdata_r <= reg_rd_i ? rd_mux : RST_ZERO;
      end
   end

   assign reg_rdata_o = rdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   property p_end_rst_flag;
      end_rst |=> status_r[IRQ_END_RST] && irq_o;
   endproperty
   a_end_rst_flag: assert property (p_end_rst_flag) else $error("end reset flag lost");

   property p_end_rst_clear;
      end_rst |=> (mask_r == RST_MASK) && (ep_enable_o == '0) && (ep_kind_o == '0);
   endproperty
   a_end_rst_clear: assert property (p_end_rst_clear) else $error("reset left state");

   property p_susp_flag;
      bus_evt_i.suspend |=> status_r[IRQ_SUSPEND] && suspended_r;
   endproperty
   a_susp_flag: assert property (p_susp_flag) else $error("suspend not flagged");

   property p_mask_gate;
      ((stat_view & mask_r) == RST_ZERO) && !stat_view[IRQ_END_RST] |-> !irq_o;
   endproperty
   a_mask_gate: assert property (p_mask_gate) else $error("unmasked irq raised");

   property p_read_keeps;
      status_r[IRQ_SUSPEND] && reg_rd_i && sel_stat |=> status_r[IRQ_SUSPEND];
   endproperty
   a_read_keeps: assert property (p_read_keeps) else $error("read cleared flag");

   property p_clear_write;
      reg_wr_i && sel_clr && reg_wdata_i[IRQ_SUSPEND] && !bus_evt_i.suspend
         |=> !status_r[IRQ_SUSPEND];
   endproperty
   a_clear_write: assert property (p_clear_write) else $error("clear ignored");

   property p_wakeup;
      $rose(rsm_sync_r) |=> status_r[IRQ_WAKEUP] && !suspended_r;
   endproperty
   a_wakeup: assert property (p_wakeup) else $error("wakeup not flagged");

   property p_resume_path;
      $rose(bus_resume_i) && !rsm_sync_r |-> ##[1:4] status_r[IRQ_WAKEUP];
   endproperty
   a_resume_path: assert property (p_resume_path) else $error("resume not seen");

   property p_pullup_hold;
      suspended_r && pullup_dp_o && !(reg_wr_i && sel_xcvr) |=> pullup_dp_o;
   endproperty
   a_pullup_hold: assert property (p_pullup_hold) else $error("pullup dropped");

   property p_xcvr_write;
      reg_wr_i && sel_xcvr |=> (xcvr_off_o == $past(reg_wdata_i[BIT_XCVR_OFF]))
                              && (pullup_dp_o == $past(reg_wdata_i[BIT_PULLUP]));
   endproperty
   a_xcvr_write: assert property (p_xcvr_write) else $error("xcvr write lost");

   property p_enable_set;
      reg_wr_i && sel_en && !end_rst |=> ((mask_r & $past(reg_wdata_i) & IRQ_VALID)
                                          == ($past(reg_wdata_i) & IRQ_VALID));
   endproperty
   a_enable_set: assert property (p_enable_set) else $error("enable not set");

   property p_disable_clr;
      reg_wr_i && sel_dis && !end_rst |=> ((mask_r & $past(reg_wdata_i)) == RST_ZERO);
   endproperty
   a_disable_clr: assert property (p_disable_clr) else $error("disable not cleared");

   property p_wo_zero;
      reg_rd_i && (sel_en || sel_dis || sel_clr) |=> reg_rdata_o == RST_ZERO;
   endproperty
   a_wo_zero: assert property (p_wo_zero) else $error("write only read nonzero");

   property p_state_cause;
      (state_r != $past(state_r)) |-> $past(end_rst) || $past(addr_en_r) || $past(config_r)
         || !$past(pullup_r) || ($past(pullup_r) != $past(pullup_r, 2))
         || ($past(state_r) == ST_POWERED);
   endproperty
   a_state_cause: assert property (p_state_cause) else $error("state moved alone");

endmodule : udsc_top
`default_nettype wire

//--- verif/udsc_host_mdl.sv
`timescale 1ns/100ps
`default_nettype none
module udsc_host_mdl (
   input  wire logic [2:0]          req_i,
   input  wire logic                ref_clk_i,
   output udsc_pkg::udsc_bus_evt_t  evt_o,
   output logic                     resume_o
);
   import udsc_pkg::*;
   // bus conditions as one-cycle pulses
   always_ff @(posedge ref_clk_i) begin
      evt_o <= udsc_bus_evt_t'({req_i[0], req_i[1], 14'h0000});
   end
   // resume is a bus level, present with or without a running clock
   assign resume_o = req_i[2];
endmodule : udsc_host_mdl
`default_nettype wire

//--- verif/usb_device_state_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module usb_device_state_control_tb;
   import udsc_pkg::*;
   logic          ref_clk_i = 0, reset_i = 1, wr = 0, rd = 0, res, irq, pu, xoff;
   logic          clk_run = 1, sus, fon;
   logic [5:0]    epen;
   logic [6:0]    fad;
   logic [7:0]    fwd;
   logic [17:0]   knd;
   logic [7:0]    addr = '0;
   logic [31:0]   wd = '0, rdat;
   logic [2:0]    req = '0;
   int            error_cnt = 0, comparisons = 0, cyc = 0;
   udsc_bus_evt_t evt;
   udsc_state_t   st;
   always #2.5 ref_clk_i = ~ref_clk_i & clk_run;   // stops low while clk_run is low
   udsc_host_mdl host (.req_i(req), .ref_clk_i(ref_clk_i), .evt_o(evt), .resume_o(res));
   udsc_top dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(addr),
      .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .bus_evt_i(evt),
      .bus_resume_i(res), .ep_event_i(6'h00), .ep_fifo_rdata_i(8'h3C), .ep_fifo_rd_o(),
      .ep_fifo_wr_o(), .ep_fifo_wdata_o(fwd), .ep_enable_o(epen), .ep_reset_o(),
      .ep_kind_o(knd), .irq_o(irq), .pullup_dp_o(pu), .xcvr_off_o(xoff), .func_on_o(fon),
      .func_addr_o(fad), .dev_state_o(st), .suspended_o(sus));
   ////////////////////////////////////////////////////////////////
   // compare and count
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD %0t got %h want %h", $time, s, e);
      end
   endtask : chk
   // one-cycle write strobe
   task automatic wr32(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      wr <= 1;
      addr <= a;
      wd <= d;
      @(posedge ref_clk_i);
      wr <= 0;
   endtask : wr32
   // one-cycle read, data taken the cycle after
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge ref_clk_i);
      rd <= 1;
      addr <= a;
      @(posedge ref_clk_i);
      rd <= 0;
      #1 chk(rdat & m, e);
   endtask : rdchk
   // host request for one cycle, then settle
   task automatic ev(input logic [2:0] m);
      @(posedge ref_clk_i);
      req <= m;
      @(posedge ref_clk_i);
      req <= '0;
      repeat (4) @(posedge ref_clk_i);
   endtask : ev
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_of_test
   // hang guard
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge ref_clk_i);
      reset_i <= 0;
      @(posedge ref_clk_i);
      rdchk(8'h08, '1, 32'h100);
      rdchk(8'h18, '1, 32'h1200);
      rdchk(8'h74, '1, 32'h100);
      rdchk(8'h10, '1, 32'h0);
      rdchk(8'h0C, '1, 32'h0);
      $display("reset test done");
      wr32(8'h10, 32'h101);
      rdchk(8'h18, '1, 32'h1301);
      wr32(8'h14, 32'h1);
      rdchk(8'h18, '1, 32'h1300);
      wr32(8'h18, 32'h0);
      rdchk(8'h18, '1, 32'h1300);
      wr32(8'h74, 32'h300);
      #1 chk({pu, xoff}, 2'b11);
      wr32(8'h74, 32'h200);
      #1 chk({pu, xoff}, 2'b10);
      $display("mask test done");
      ev(3'b010);
      rdchk(8'h1C, 32'h100, 32'h100);
      chk(irq, 1);
      wr32(8'h14, 32'h100);
      #1 chk(irq, 0);
      rdchk(8'h1C, 32'h100, 32'h100);
      wr32(8'h20, 32'h100);
      rdchk(8'h1C, 32'h100, 32'h0);
      $display("suspend test done");
      wr32(8'h34, 32'h8100);
      rdchk(8'h34, '1, 32'h8100);
      wr32(8'h10, 32'h2);
      ev(3'b001);
      rdchk(8'h34, '1, 32'h0);
      rdchk(8'h18, '1, 32'h1200);
      rdchk(8'h1C, 32'h1000, 32'h1000);
      chk(irq, 1);
      chk(st, ST_DEFAULT);
      $display("bus reset test done");
      wr32(8'h30, 32'h8000);
      wr32(8'h10, 32'h2101);
      wr32(8'h74, 32'h200);
      rdchk(8'h18, '1, 32'h3301);
      wr32(8'h04, 32'h1);
      wr32(8'h08, 32'h105);
      rdchk(8'h04, '1, 32'h1);
      chk({fon, fad, st}, {1'b1, 7'h05, ST_ADDRESS});
      wr32(8'h04, 32'h3);
      wr32(8'h34, 32'h8200);
      #1 chk({epen, knd, st}, {6'h03, 18'h00010, ST_CONFIGURED});
      wr32(8'h58, 32'h1A5);
      #1 chk(fwd, 8'hA5);
      rdchk(8'h58, '1, 32'h3C);
      $display("enumeration test done");
      @(posedge ref_clk_i);
      req[2] <= 1;
      repeat (6) @(posedge ref_clk_i);
      req[2] <= 0;
      rdchk(8'h1C, 32'h2000, 32'h2000);
      $display("resume test done");
      ev(3'b010);
      #1 chk({sus, pu}, 2'b11);
      wr32(8'h74, 32'h300);
      wr32(8'h20, 32'h2100);
      rdchk(8'h1C, 32'h2100, 32'h0);
      clk_run = 0;
      #5_000_000 req[2] <= 1; // wakeup K after 5 ms with clock stopped
      #1_000_000 req[2] <= 0; // K held 1 ms
      #100 clk_run = 1; // clock back before any access
      repeat (4) @(posedge ref_clk_i);
      rdchk(8'h1C, 32'h2000, 32'h2000);
      chk({sus, pu}, 2'b01);
      wr32(8'h20, 32'h2000);
      wr32(8'h74, 32'h200);
      rdchk(8'h1C, 32'h2000, 32'h0);
      chk({pu, xoff}, 2'b10);
      $display("clock stop test done");
      end_of_test();
   end
endmodule : usb_device_state_control_tb
`default_nettype wire
